// [common/ebac_pkg.sv]
// Shared constants and types of the byte-wide nonvolatile access controller.
`default_nettype none
package ebac_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int DEPTH  = 512;
  localparam int TICK_W = 20;
  localparam int PADDR_W = 12;
  localparam int IRQ_W  = 2;

  localparam logic [ADDR_W-1:0] LAST_ADDR = 9'h1FF;

  localparam logic [PADDR_W-1:0] OFF_PTR      = 12'h000;
  localparam logic [PADDR_W-1:0] OFF_BUF      = 12'h004;
  localparam logic [PADDR_W-1:0] OFF_CTRL     = 12'h008;
  localparam logic [PADDR_W-1:0] OFF_IRQ_STAT = 12'h00C;
  localparam logic [PADDR_W-1:0] OFF_IRQ_CLR  = 12'h010;
  localparam logic [PADDR_W-1:0] OFF_IRQ_EN   = 12'h014;

  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_PROG_BIT = 1;
  localparam int CTRL_ARM_BIT  = 2;
  localparam int CTRL_MODE_LO  = 4;
  localparam int CTRL_MODE_HI  = 5;

  localparam int IRQ_OP_DONE   = 0;
  localparam int IRQ_READ_DONE = 1;

  localparam logic [ADDR_W-1:0] PTR_RST  = 9'h000;
  localparam logic [DATA_W-1:0] BUF_RST  = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_RST  = 2'h0;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

  localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
  localparam logic [2:0] READ_STALL_CYC = 3'h4;
  localparam logic [2:0] PROG_STALL_CYC = 3'h2;

  // Oscillator ticks per operation; plain defaults, shortened in simulation.
  localparam logic [TICK_W-1:0] ERASE_WRITE_TICKS_DEF = 20'h4E20;
  localparam logic [TICK_W-1:0] ERASE_TICKS_DEF       = 20'h2710;
  localparam logic [TICK_W-1:0] WRITE_TICKS_DEF       = 20'h2710;

  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'h0,
    MODE_ERASE  = 2'h1,
    MODE_WRITE  = 2'h2,
    MODE_RSVD   = 2'h3
  } ebac_mode_t;

  localparam ebac_mode_t MODE_RST = MODE_ATOMIC;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_STALL = 2'b10
  } ebac_apb_state_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    ebac_mode_t        mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ebac_mem_req_t;

  typedef struct packed {
    ebac_mode_t        mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ebac_job_t;
endpackage
`default_nettype wire

// [src/ebac_nvm_array.sv]
// Storage array of 512 bytes with registered read data.
`timescale 1ns/1ps
`default_nettype none
module ebac_nvm_array (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire ebac_pkg::ebac_mem_req_t req,
  output logic [ebac_pkg::DATA_W-1:0] rdata
);
  logic [ebac_pkg::DATA_W-1:0] cells [0:ebac_pkg::DEPTH-1];

  // A write-only pass can only clear bits, so an unerased byte ends up mixed.
  always_ff @(posedge pclk) begin
    if (req.wr) begin
      case (req.mode)
        ebac_pkg::MODE_ERASE: cells[req.addr] <= ebac_pkg::ERASED_BYTE;
        ebac_pkg::MODE_WRITE: cells[req.addr] <= cells[req.addr] & req.data;
        default:              cells[req.addr] <= req.data;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= ebac_pkg::BUF_RST;
    end else if (req.rd) begin
      rdata <= cells[req.addr];
    end
  end
endmodule // ebac_nvm_array
`default_nettype wire

// [src/ebac_prog_timer.sv]
// Self-timer of a programming pass, counted on calibrated oscillator ticks.
`timescale 1ns/1ps
`default_nettype none
module ebac_prog_timer (
  input  wire logic                        pclk,
  input  wire logic                        por_n,
  input  wire logic                        start,
  input  wire logic [ebac_pkg::TICK_W-1:0] ticks,
  input  wire logic                        osc_tick,
  output logic                             busy,
  output logic                             done
);
  logic                        run;
  logic [ebac_pkg::TICK_W-1:0] remain;
  logic                        last_tick;

  assign last_tick = run && osc_tick && (remain <= 20'h00001);
  // Busy spans the done cycle so the array write is never overlapped.
  assign busy = run | done;

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      run    <= 1'b0;
      remain <= 20'h00000;
    end else if (start) begin
      run    <= 1'b1;
      remain <= ticks;
    end else if (last_tick) begin
      run    <= 1'b0;
      remain <= 20'h00000;
    end else if (run && osc_tick) begin
      remain <= remain - 20'h00001;
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      done <= 1'b0;
    end else begin
      done <= last_tick;
    end
  end
endmodule // ebac_prog_timer
`default_nettype wire

// [src/ebac_ctrl.sv]
// APB-attached controller for byte reads and programming of the data array.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - 512-byte array, each byte individually accessible
// - Pointer, buffer, control reachable as registers
// - Read start stalls the bus four cycles
// - Program start stalls the bus two cycles
// - Mode zero: armed strobe erases then writes
// - Mode one: armed strobe erases only
// - Mode two: armed strobe writes without erase
// - Program strobe reads one until completion
// - No array access while programming
// - Operation length counted on oscillator ticks
// - Mode writes ignored while busy
// - Reset clears mode unless still busy
// - Read strobe loads addressed byte into buffer
module ebac_ctrl #(
  parameter logic [ebac_pkg::TICK_W-1:0] ERASE_WRITE_TICKS = ebac_pkg::ERASE_WRITE_TICKS_DEF,
  parameter logic [ebac_pkg::TICK_W-1:0] ERASE_TICKS       = ebac_pkg::ERASE_TICKS_DEF,
  parameter logic [ebac_pkg::TICK_W-1:0] WRITE_TICKS       = ebac_pkg::WRITE_TICKS_DEF
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         por_n,
  input  wire logic                         osc_tick,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ebac_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic                              irq
);
  ebac_pkg::ebac_apb_state_t    state;
  logic [2:0]                   stall_cnt;
  logic [2:0]                   arm_cnt;
  logic [ebac_pkg::ADDR_W-1:0]  ptr;
  logic [ebac_pkg::DATA_W-1:0]  buffer;
  ebac_pkg::ebac_mode_t         mode;
  ebac_pkg::ebac_mode_t         mode_req;
  ebac_pkg::ebac_job_t          job;
  ebac_pkg::ebac_mem_req_t      mem_req;
  logic [ebac_pkg::DATA_W-1:0]  arr_rdata;
  logic [ebac_pkg::IRQ_W-1:0]   irq_stat;
  logic [ebac_pkg::IRQ_W-1:0]   irq_en;
  logic [ebac_pkg::IRQ_W-1:0]   irq_set;
  logic [ebac_pkg::IRQ_W-1:0]   irq_clr;
  logic [31:0]                  next_prdata;
  logic                         access;
  logic                         commit;
  logic                         mapped;
  logic                         wr_ctrl;
  logic                         arm_active;
  logic                         arm_set;
  logic                         read_start;
  logic                         prog_start;
  logic                         rd_pending;
  logic                         busy;
  logic                         tim_done;

  function automatic logic hit(input logic [ebac_pkg::PADDR_W-1:0] a,
                               input logic [ebac_pkg::PADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [ebac_pkg::TICK_W-1:0] ticks_for(input ebac_pkg::ebac_mode_t m);
    case (m)
      ebac_pkg::MODE_ERASE: ticks_for = ERASE_TICKS;
      ebac_pkg::MODE_WRITE: ticks_for = WRITE_TICKS;
      default:              ticks_for = ERASE_WRITE_TICKS;
    endcase
  endfunction

  assign access  = psel & penable;
  // Side effects act on the first access cycle; the stall then follows.
  assign commit  = access & (state == ebac_pkg::ST_IDLE);
  assign mapped  = hit(paddr, ebac_pkg::OFF_PTR) | hit(paddr, ebac_pkg::OFF_BUF) |
                   hit(paddr, ebac_pkg::OFF_CTRL) | hit(paddr, ebac_pkg::OFF_IRQ_STAT) |
                   hit(paddr, ebac_pkg::OFF_IRQ_CLR) | hit(paddr, ebac_pkg::OFF_IRQ_EN);
  assign wr_ctrl  = commit & pwrite & hit(paddr, ebac_pkg::OFF_CTRL);
  assign mode_req = ebac_pkg::ebac_mode_t'(pwdata[ebac_pkg::CTRL_MODE_HI:ebac_pkg::CTRL_MODE_LO]);
  assign arm_active = (arm_cnt != 3'h0);
  assign arm_set  = wr_ctrl & pwdata[ebac_pkg::CTRL_ARM_BIT];
  assign read_start = wr_ctrl & pwdata[ebac_pkg::CTRL_READ_BIT] & ~busy;
  // The strobe must land in a later write than the arm, inside its window.
  assign prog_start = wr_ctrl & pwdata[ebac_pkg::CTRL_PROG_BIT] & arm_active & ~busy &
                      (mode_req != ebac_pkg::MODE_RSVD);

  always_comb begin
    pready = 1'b1;
    case (state)
      ebac_pkg::ST_IDLE:  pready = ~(commit & (read_start | prog_start));
      ebac_pkg::ST_STALL: pready = (stall_cnt == 3'h0);
      default:            pready = 1'b1;
    endcase
  end

  assign pslverr = access & pready & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ebac_pkg::ST_IDLE;
      stall_cnt <= 3'h0;
    end else begin
      case (state)
        ebac_pkg::ST_IDLE: begin
          if (read_start) begin
            state     <= ebac_pkg::ST_STALL;
            stall_cnt <= ebac_pkg::READ_STALL_CYC - 3'h1;
          end else if (prog_start) begin
            state     <= ebac_pkg::ST_STALL;
            stall_cnt <= ebac_pkg::PROG_STALL_CYC - 3'h1;
          end
        end
        ebac_pkg::ST_STALL: begin
          if (stall_cnt == 3'h0) begin
            state <= ebac_pkg::ST_IDLE;
          end else begin
            stall_cnt <= stall_cnt - 3'h1;
          end
        end
        default: state <= ebac_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_cnt <= 3'h0;
    end else if (arm_set) begin
      arm_cnt <= ebac_pkg::ARM_WINDOW_CYC;
    end else if (arm_active) begin
      arm_cnt <= arm_cnt - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr <= ebac_pkg::PTR_RST;
    end else if (commit & pwrite & hit(paddr, ebac_pkg::OFF_PTR)) begin
      ptr <= pwdata[ebac_pkg::ADDR_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= read_start;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer <= ebac_pkg::BUF_RST;
    end else if (rd_pending) begin
      buffer <= arr_rdata;
    end else if (commit & pwrite & hit(paddr, ebac_pkg::OFF_BUF)) begin
      buffer <= pwdata[ebac_pkg::DATA_W-1:0];
    end
  end

  // Mode and job live on the power-on reset so a bus reset cannot cut a pass short.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      mode <= ebac_pkg::MODE_RST;
    end else if (!presetn) begin
      if (!busy) begin
        mode <= ebac_pkg::MODE_RST;
      end
    end else if (wr_ctrl & ~busy) begin
      mode <= mode_req;
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      job <= '0;
    end else if (prog_start) begin
      job.mode <= mode_req;
      job.addr <= ptr;
      job.data <= buffer;
    end
  end

  ebac_prog_timer u_timer (
    .pclk     (pclk),
    .por_n    (por_n),
    .start    (prog_start),
    .ticks    (ticks_for(mode_req)),
    .osc_tick (osc_tick),
    .busy     (busy),
    .done     (tim_done)
  );

  always_comb begin
    mem_req      = '0;
    mem_req.rd   = read_start;
    mem_req.wr   = tim_done;
    mem_req.mode = job.mode;
    mem_req.addr = busy ? job.addr : ptr;
    mem_req.data = job.data;
  end

  ebac_nvm_array u_array (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (mem_req),
    .rdata   (arr_rdata)
  );

  assign irq_set[ebac_pkg::IRQ_OP_DONE]   = tim_done;
  assign irq_set[ebac_pkg::IRQ_READ_DONE] = rd_pending;
  assign irq_clr = (commit & pwrite & hit(paddr, ebac_pkg::OFF_IRQ_CLR)) ?
                   pwdata[ebac_pkg::IRQ_W-1:0] : 2'h0;

  // A clear in the same cycle as a new event leaves the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= ebac_pkg::IRQ_RST;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= ebac_pkg::IRQ_RST;
    end else if (commit & pwrite & hit(paddr, ebac_pkg::OFF_IRQ_EN)) begin
      irq_en <= pwdata[ebac_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat & irq_en);

  always_comb begin
    next_prdata = 32'h00000000;
    if (hit(paddr, ebac_pkg::OFF_PTR)) begin
      next_prdata[ebac_pkg::ADDR_W-1:0] = ptr;
    end else if (hit(paddr, ebac_pkg::OFF_BUF)) begin
      next_prdata[ebac_pkg::DATA_W-1:0] = buffer;
    end else if (hit(paddr, ebac_pkg::OFF_CTRL)) begin
      next_prdata[ebac_pkg::CTRL_MODE_HI:ebac_pkg::CTRL_MODE_LO] = mode;
      next_prdata[ebac_pkg::CTRL_ARM_BIT]  = arm_active;
      next_prdata[ebac_pkg::CTRL_PROG_BIT] = busy;
    end else if (hit(paddr, ebac_pkg::OFF_IRQ_STAT)) begin
      next_prdata[ebac_pkg::IRQ_W-1:0] = irq_stat;
    end else if (hit(paddr, ebac_pkg::OFF_IRQ_EN)) begin
      next_prdata[ebac_pkg::IRQ_W-1:0] = irq_en;
    end
  end

  // Read data is captured in the setup cycle, so reads never stall.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= next_prdata;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_read_stall_len: assert property (read_start |-> (!pready)[*4] ##1 pready)
    else $error("read stall not four cycles");
  a_prog_stall_len: assert property (prog_start |-> (!pready)[*2] ##1 pready)
    else $error("program stall not two cycles");
  a_strobe_busy: assert property (prog_start |=> busy ##1 busy)
    else $error("program strobe dropped early");
  a_done_ends_busy: assert property ($fell(busy) |-> $past(tim_done))
    else $error("busy fell without completion");
  a_no_overlap: assert property (busy |-> !read_start && !prog_start)
    else $error("array access started while busy");
  a_mode_frozen: assert property (busy && $past(busy) && presetn |-> $stable(mode))
    else $error("mode changed while busy");
  a_arm_needed: assert property (wr_ctrl && !arm_active |-> !prog_start)
    else $error("program started without arm");
  a_arm_expiry: assert property (arm_set ##1 !arm_set [*4] |=> !arm_active)
    else $error("arm window not four cycles");
  a_read_fills: assert property (read_start |-> ##2 buffer == $past(arr_rdata))
    else $error("buffer not loaded by read");
  a_busy_read: assert property (busy && wr_ctrl && pwdata[ebac_pkg::CTRL_READ_BIT] |=> $stable(buffer) ##1 $stable(buffer))
    else $error("buffer changed by ignored read");
  a_mode_job: assert property (prog_start |=> job.mode == $past(mode_req))
    else $error("job mode not latched");

  c_read: cover property (read_start ##5 pready);
  c_atomic: cover property (prog_start && mode_req == ebac_pkg::MODE_ATOMIC);
  c_erase: cover property (prog_start && mode_req == ebac_pkg::MODE_ERASE);
  c_write: cover property (prog_start && mode_req == ebac_pkg::MODE_WRITE);
endmodule // ebac_ctrl
`default_nettype wire

// [tb/ebac_apb_master.sv]
// Bus master model of the processor side, issuing one register transfer per call.
`timescale 1ns/1ps
`default_nettype none
module ebac_apb_master (
  input  wire logic                         pclk,
  output logic                              psel,
  output logic                              penable,
  output logic                              pwrite,
  output logic [ebac_pkg::PADDR_W-1:0]      paddr,
  output logic [31:0]                       pwdata,
  input  wire logic [31:0]                  prdata,
  input  wire logic                         pready,
  input  wire logic                         pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // Ready is sampled at the rising edge itself, and the request moves only just after an edge.
  task automatic xfer(input logic wr, input logic [ebac_pkg::PADDR_W-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output int stalls, output bit ok);
    int k;
    ok = 1'b0;
    stalls = 0;
    rd = 32'h0000_0000;
    err = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 64 && !ok; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        ok = 1'b1;
        rd = prdata;
        err = pslverr;
      end else begin
        stalls++;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // ebac_apb_master
`default_nettype wire

// [tb/eeprom_byte_access_controller_tb.sv]
// Self-checking bench of the nonvolatile byte access controller.
`timescale 1ns/1ps
`default_nettype none
module eeprom_byte_access_controller_tb;
  logic        pclk;
  logic        presetn;
  logic        por_n;
  logic        osc_tick;
  logic        osc_en;
  logic [1:0]  tick_cnt;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rdata;
  logic        err;
  int          stalls;
  int          failures;
  int          n_compared;

  ebac_ctrl #(.ERASE_WRITE_TICKS(20'h00006), .ERASE_TICKS(20'h00008), .WRITE_TICKS(20'h00004)) DUT (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .osc_tick(osc_tick), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));

  ebac_apb_master m_cpu (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // One oscillator tick every four bus cycles; stopping it must freeze programming.
  always @(posedge pclk) begin
    if (!por_n) begin
      tick_cnt <= 2'h0;
      osc_tick <= 1'b0;
    end else begin
      tick_cnt <= tick_cnt + 2'h1;
      osc_tick <= osc_en && (tick_cnt == 2'h3);
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    bit ok;
    m_cpu.xfer(wr, a, wd, rdata, err, stalls, ok);
    if (!ok) begin
      failures++;
      $display("ERROR %0t: bus slave never ready", $time);
      test_done();
    end
  endtask

  task automatic wait_idle;
    int k;
    for (k = 0; k < 200; k++) begin
      xfer(1'b0, ebac_pkg::OFF_CTRL, 32'h0);
      if (rdata[ebac_pkg::CTRL_PROG_BIT] === 1'b0) return;
    end
    failures++;
    $display("ERROR %0t: programming never finished", $time);
    test_done();
  endtask

  task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] mode);
    xfer(1'b1, ebac_pkg::OFF_PTR, {23'h0, a});
    xfer(1'b1, ebac_pkg::OFF_BUF, {24'h0, d});
    xfer(1'b1, ebac_pkg::OFF_CTRL, {26'h0, mode, 4'h4});
    xfer(1'b1, ebac_pkg::OFF_CTRL, {26'h0, mode, 4'h2});
    check(32'(stalls), 32'h2);
  endtask

  task automatic read_byte(input logic [8:0] a, input logic [7:0] d);
    xfer(1'b1, ebac_pkg::OFF_PTR, {23'h0, a});
    xfer(1'b1, ebac_pkg::OFF_CTRL, 32'h1);
    check(32'(stalls), 32'h4);
    xfer(1'b0, ebac_pkg::OFF_BUF, 32'h0);
    check(rdata, {24'h0, d});
  endtask

  task automatic chk_irq(input logic e);
    @(negedge pclk);
    check({31'h0, irq}, {31'h0, e});
  endtask

  initial begin
    presetn = 1'b0;
    por_n = 1'b0;
    osc_en = 1'b1;
    failures = 0;
    n_compared = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    xfer(1'b0, ebac_pkg::OFF_PTR, 32'h0);
    check(rdata, 32'h0);
    xfer(1'b0, ebac_pkg::OFF_CTRL, 32'h0);
    check(rdata, 32'h0);
    xfer(1'b0, 12'h040, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test reset done");

    prog(ebac_pkg::LAST_ADDR, 8'h5A, 2'h0);
    xfer(1'b0, ebac_pkg::OFF_CTRL, 32'h0);
    check(rdata & 32'h32, 32'h2);
    osc_en <= 1'b0;
    xfer(1'b1, ebac_pkg::OFF_CTRL, 32'h21);
    check(32'(stalls), 32'h0);
    xfer(1'b0, ebac_pkg::OFF_BUF, 32'h0);
    check(rdata, 32'h5A);
    xfer(1'b1, ebac_pkg::OFF_CTRL, 32'h14);
    xfer(1'b1, ebac_pkg::OFF_CTRL, 32'h12);
    check(32'(stalls), 32'h0);
    repeat (40) @(posedge pclk);
    xfer(1'b0, ebac_pkg::OFF_CTRL, 32'h0);
    check(rdata & 32'h32, 32'h2);
    osc_en <= 1'b1;
    wait_idle();
    read_byte(ebac_pkg::LAST_ADDR, 8'h5A);
    $display("test atomic done");

    xfer(1'b0, ebac_pkg::OFF_IRQ_STAT, 32'h0);
    check(rdata, 32'h3);
    xfer(1'b1, ebac_pkg::OFF_IRQ_EN, 32'h3);
    chk_irq(1'b1);
    xfer(1'b1, ebac_pkg::OFF_IRQ_EN, 32'h0);
    chk_irq(1'b0);
    xfer(1'b1, ebac_pkg::OFF_IRQ_EN, 32'h1);
    chk_irq(1'b1);
    xfer(1'b1, ebac_pkg::OFF_IRQ_CLR, 32'h1);
    chk_irq(1'b0);
    xfer(1'b0, ebac_pkg::OFF_IRQ_STAT, 32'h0);
    check(rdata, 32'h2);
    $display("test interrupt done");

    prog(9'h001, 8'hC3, 2'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, ebac_pkg::OFF_CTRL, 32'h0);
    check(rdata & 32'h32, 32'h12);
    wait_idle();
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, ebac_pkg::OFF_CTRL, 32'h0);
    check(rdata, 32'h0);
    read_byte(9'h001, 8'hFF);
    // The cell was erased just above, so a write-only pass is legal here.
    prog(9'h001, 8'h3C, 2'h2);
    wait_idle();
    read_byte(9'h001, 8'h3C);
    $display("test split done");

    xfer(1'b1, ebac_pkg::OFF_CTRL, 32'h4);
    xfer(1'b0, ebac_pkg::OFF_CTRL, 32'h0);
    check(rdata & 32'h4, 32'h4);
    repeat (5) @(posedge pclk);
    xfer(1'b1, ebac_pkg::OFF_CTRL, 32'h2);
    check(32'(stalls), 32'h0);
    xfer(1'b1, ebac_pkg::OFF_CTRL, 32'h6);
    check(32'(stalls), 32'h0);
    xfer(1'b1, ebac_pkg::OFF_CTRL, 32'h34);
    xfer(1'b1, ebac_pkg::OFF_CTRL, 32'h32);
    check(32'(stalls), 32'h0);
    xfer(1'b0, ebac_pkg::OFF_CTRL, 32'h0);
    check(rdata & 32'h2, 32'h0);
    $display("test arm done");
    test_done();
  end
endmodule // eeprom_byte_access_controller_tb
`default_nettype wire
